// ===== logic/fe_pkg.sv
// constants, carriers and helpers for the dram bank memory item front end
`default_nettype none

package fe_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int N_ITEMS     = 2;
  localparam int OWN_W       = 1;
  localparam int ACCESS_W    = 128;
  localparam int NARROW_W    = 64;
  localparam int ITEM_DATA_W = 64;
  localparam int BANK_ADDR_W = 24;
  localparam int LIMIT_W     = 25;
  localparam int TAG_W       = 2;
  localparam int QUEUE_DEPTH = 4;
  localparam int QPTR_W      = 2;
  localparam int QCNT_W      = 3;
  localparam int GRANT_W     = 8;

  // ****************************************************************
  // values
  // ****************************************************************
  localparam logic [GRANT_W-1:0]     GRANT_CYCLES = 8'h32;
  localparam logic [BANK_ADDR_W-1:0] ITEM0_BASE   = 24'h00_0000;
  localparam logic [BANK_ADDR_W-1:0] ITEM1_BASE   = 24'h80_0000;
  localparam logic [LIMIT_W-1:0]     ITEM_WORDS   = 25'h080_0000;
  localparam logic [LIMIT_W-1:0]     BANK_WORDS   = 25'h100_0000;
  localparam logic [BANK_ADDR_W-1:0] FIFO_WORDS   = 24'hFF_FFFF;
  localparam logic [TAG_W-1:0]       TAG_DIRECT   = 2'h2;
  localparam logic [TAG_W-1:0]       TAG_FIFO     = 2'h3;
  localparam logic [QCNT_W-1:0]      QUEUE_FULL   = 3'h4;
  localparam int OPTIMAL_CLK_MHZ = 100;
  localparam int CORE_CLK_MHZ    = 250;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic [BANK_ADDR_W-1:0] addr;
    logic [ITEM_DATA_W-1:0] data;
  } fe_item_req_s;

  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic [BANK_ADDR_W-1:0] addr;
    logic [ACCESS_W-1:0]    data;
  } fe_req_s;

  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic [TAG_W-1:0]       tag;
    logic [BANK_ADDR_W-1:0] addr;
    logic [ACCESS_W-1:0]    data;
  } fe_cmd_s;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [BANK_ADDR_W-1:0] item_base(input int idx);
    return (idx == 0) ? ITEM0_BASE : ITEM1_BASE;
  endfunction

  function automatic logic [ACCESS_W-1:0] fit_width(
    input logic [ACCESS_W-1:0] d,
    input logic                narrow);
    return narrow ? {{(ACCESS_W-NARROW_W){1'b0}}, d[NARROW_W-1:0]} : d;
  endfunction

  function automatic logic [OWN_W-1:0] rr_next(
    input logic [OWN_W-1:0]   cur,
    input logic [N_ITEMS-1:0] pend);
    logic [OWN_W-1:0] pick;
    int               idx;
    pick = cur;
    for (int k = N_ITEMS; k >= 1; k--) begin
      idx = (int'(cur) + k) % N_ITEMS;
      if (pend[idx]) begin
        pick = OWN_W'(idx);
      end
    end
    return pick;
  endfunction

endpackage

`default_nettype wire

// ===== logic/fe_req_queue.sv
// in-order request queue with partition address translation
`default_nettype none

module fe_req_queue (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire fe_pkg::fe_req_s             req_in,
  input  wire logic [fe_pkg::BANK_ADDR_W-1:0] base_in,
  input  wire logic [fe_pkg::LIMIT_W-1:0]  limit_in,
  input  wire logic                        pop_in,
  output logic                             ready_out,
  output fe_pkg::fe_req_s                  head_out,
  output logic                             range_err_out
);
  import fe_pkg::*;

  fe_req_s           mem [QUEUE_DEPTH];
  logic [QPTR_W-1:0] wr_ptr;
  logic [QPTR_W-1:0] rd_ptr;
  logic [QCNT_W-1:0] count;

  wire logic in_range = {1'b0, req_in.addr} < limit_in;
  wire logic take     = req_in.valid & ready_out;
  wire logic push     = take & in_range;
  wire logic do_pop   = pop_in & (count != '0);
  wire logic [QCNT_W-1:0] next_count =
    count + QCNT_W'(push) - QCNT_W'(do_pop);
  wire logic [BANK_ADDR_W-1:0] bank_addr =
    BANK_ADDR_W'(base_in + req_in.addr);
  wire fe_req_s entry = {1'b1, req_in.write, bank_addr, req_in.data};
  wire fe_req_s head  = mem[rd_ptr];

  assign head_out = {count != '0, head.write, head.addr, head.data};

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= entry;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      count         <= '0;
      ready_out     <= 1'b0;
      range_err_out <= 1'b0;
    end else begin
      wr_ptr        <= wr_ptr + QPTR_W'(push);
      rd_ptr        <= rd_ptr + QPTR_W'(do_pop);
      count         <= next_count;
      ready_out     <= next_count != QUEUE_FULL;
      range_err_out <= take & !in_range;
    end
  end

endmodule

`default_nettype wire

// ===== logic/fe_bank_front.sv
// dram bank front end: memory items, arbiter, direct and fifo paths
`default_nettype none

module fe_bank_front (
  input  wire logic                          CORE_CLK_IN,
  input  wire logic                          RESETN_IN,
  input  wire logic                          DIRECT_SEL_IN,
  input  wire logic                          FIFO_MODE_IN,
  input  wire logic                          NARROW_IN,
  input  wire fe_pkg::fe_item_req_s [fe_pkg::N_ITEMS-1:0] ITEM_REQ_IN,
  output logic [fe_pkg::N_ITEMS-1:0]         ITEM_READY_OUT,
  output logic [fe_pkg::N_ITEMS:0]           RANGE_ERR_OUT,
  output logic [fe_pkg::N_ITEMS-1:0]         ITEM_RD_VALID_OUT,
  output logic [fe_pkg::ITEM_DATA_W-1:0]     ITEM_RD_DATA_OUT,
  input  wire fe_pkg::fe_req_s               DIR_REQ_IN,
  output logic                               DIR_READY_OUT,
  output logic                               DIR_FULL_OUT,
  input  wire logic                          DIR_POP_IN,
  output logic                               DIR_AVAIL_OUT,
  output logic                               DIR_RD_VALID_OUT,
  output logic [fe_pkg::ACCESS_W-1:0]        DIR_RD_DATA_OUT,
  output fe_pkg::fe_cmd_s                    CMD_OUT,
  input  wire logic                          CMD_READY_IN,
  input  wire logic                          RD_VALID_IN,
  input  wire logic [fe_pkg::TAG_W-1:0]      RD_TAG_IN,
  input  wire logic [fe_pkg::ACCESS_W-1:0]   RD_DATA_IN
);
  import fe_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [OWN_W-1:0]       owner;
  logic [GRANT_W-1:0]     win_left;
  logic [BANK_ADDR_W-1:0] fifo_wr_addr;
  logic [BANK_ADDR_W-1:0] fifo_issued;
  logic [BANK_ADDR_W-1:0] fifo_fetch;
  logic [BANK_ADDR_W-1:0] fifo_occ;
  logic                   fetch_busy;
  logic                   hold_v;

  fe_req_s [N_ITEMS:0]    q_req;
  fe_req_s [N_ITEMS:0]    q_head;
  logic    [N_ITEMS:0]    q_pop;
  logic    [N_ITEMS:0]    q_ready;
  logic    [N_ITEMS-1:0]  item_pend;

  // ****************************************************************
  // queues
  // ****************************************************************
  // no sync stages
  // inputs are used as they arrive: the user side shares this clock,
  // which may be any clock the user picks
  // any user clock
  genvar gi;
  generate
    for (gi = 0; gi < N_ITEMS; gi++) begin : g_item
      assign q_req[gi] = {ITEM_REQ_IN[gi].valid & !DIRECT_SEL_IN,
                          ITEM_REQ_IN[gi].write,
                          ITEM_REQ_IN[gi].addr,
                          {(ACCESS_W-ITEM_DATA_W){1'b0}},
                          ITEM_REQ_IN[gi].data};
      assign item_pend[gi]      = q_head[gi].valid;
      assign ITEM_READY_OUT[gi] = q_ready[gi];
      fe_req_queue u_queue (
        .clk_in        (CORE_CLK_IN),
        .rst_n_in      (RESETN_IN),
        .req_in        (q_req[gi]),
        .base_in       (item_base(gi)),
        .limit_in      (ITEM_WORDS),
        .pop_in        (q_pop[gi]),
        .ready_out     (q_ready[gi]),
        .head_out      (q_head[gi]),
        .range_err_out (RANGE_ERR_OUT[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // direct path
  // ****************************************************************
  // fifo mode accepts only direct writes, placed at the tail while not full;
  // random access passes the address through untouched
  wire logic dir_fifo = DIRECT_SEL_IN & FIFO_MODE_IN;
  wire logic dir_ok   = !FIFO_MODE_IN | (DIR_REQ_IN.write & !DIR_FULL_OUT);
  wire logic [BANK_ADDR_W-1:0] dir_addr =
    FIFO_MODE_IN ? fifo_wr_addr : DIR_REQ_IN.addr;

  assign q_req[N_ITEMS] = {DIR_REQ_IN.valid & DIRECT_SEL_IN & dir_ok,
                           DIR_REQ_IN.write | FIFO_MODE_IN,
                           dir_addr,
                           fit_width(DIR_REQ_IN.data, NARROW_IN)};
  assign DIR_READY_OUT  = q_ready[N_ITEMS];

  fe_req_queue u_dir_queue (
    .clk_in        (CORE_CLK_IN),
    .rst_n_in      (RESETN_IN),
    .req_in        (q_req[N_ITEMS]),
    .base_in       ('0),
    .limit_in      (BANK_WORDS),
    .pop_in        (q_pop[N_ITEMS]),
    .ready_out     (q_ready[N_ITEMS]),
    .head_out      (q_head[N_ITEMS]),
    .range_err_out (RANGE_ERR_OUT[N_ITEMS])
  );

  // ****************************************************************
  // command selection
  // ****************************************************************
  wire logic cmd_free  = !CMD_OUT.valid | CMD_READY_IN;
  wire logic own_pend  = item_pend[owner];
  wire logic win_open  = win_left != '0;
  wire logic item_fire = !DIRECT_SEL_IN & cmd_free & own_pend & win_open;
  wire logic dir_fire  = DIRECT_SEL_IN & cmd_free & q_head[N_ITEMS].valid;
  wire logic fetch_go  = dir_fifo & cmd_free & !q_head[N_ITEMS].valid &
                         !hold_v & !fetch_busy & (fifo_fetch != fifo_issued);
  wire logic rotate    = !DIRECT_SEL_IN & (!win_open | !own_pend);

  wire fe_req_s own_head = q_head[owner];
  wire fe_req_s dir_head = q_head[N_ITEMS];

  fe_cmd_s next_cmd;
  assign next_cmd =
    item_fire ? {1'b1, own_head.write, TAG_W'(owner), own_head.addr,
                 own_head.data} :
    dir_fire  ? {1'b1, dir_head.write, TAG_DIRECT, dir_head.addr,
                 dir_head.data} :
    fetch_go  ? {1'b1, 1'b0, TAG_FIFO, fifo_fetch, {ACCESS_W{1'b0}}} :
                {1'b0, 1'b0, TAG_DIRECT, {BANK_ADDR_W{1'b0}},
                 {ACCESS_W{1'b0}}};

  generate
    for (gi = 0; gi < N_ITEMS; gi++) begin : g_pop
      assign q_pop[gi] = item_fire & (owner == OWN_W'(gi));
    end
  endgenerate
  assign q_pop[N_ITEMS] = dir_fire;

  // ****************************************************************
  // fifo bookkeeping
  // ****************************************************************
  wire logic fifo_enq  = dir_fifo & q_req[N_ITEMS].valid & DIR_READY_OUT;
  wire logic fifo_pop  = DIR_POP_IN & hold_v;
  wire logic fifo_ret  = RD_VALID_IN & (RD_TAG_IN == TAG_FIFO);
  wire logic dir_ret   = RD_VALID_IN & (RD_TAG_IN == TAG_DIRECT);
  wire logic [BANK_ADDR_W-1:0] next_occ =
    fifo_occ + BANK_ADDR_W'(fifo_enq) - BANK_ADDR_W'(fifo_pop);

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      CMD_OUT <= '0;
    end else if (cmd_free) begin
      CMD_OUT <= next_cmd;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      owner    <= '0;
      win_left <= GRANT_CYCLES;
    end else if (rotate) begin
      owner    <= rr_next(owner, item_pend);
      win_left <= GRANT_CYCLES;
    end else if (own_pend) begin
      win_left <= win_left - GRANT_W'(1);
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      fifo_wr_addr <= '0;
      fifo_issued  <= '0;
      fifo_fetch   <= '0;
      fifo_occ     <= '0;
      fetch_busy   <= 1'b0;
      hold_v       <= 1'b0;
      DIR_FULL_OUT <= 1'b0;
    end else begin
      fifo_wr_addr <= fifo_wr_addr + BANK_ADDR_W'(fifo_enq);
      fifo_issued  <= fifo_issued + BANK_ADDR_W'(dir_fire & dir_fifo);
      fifo_fetch   <= fifo_fetch + BANK_ADDR_W'(fetch_go);
      fifo_occ     <= next_occ;
      fetch_busy   <= fetch_go | (fetch_busy & !fifo_ret);
      hold_v       <= fifo_ret | (hold_v & !fifo_pop);
      DIR_FULL_OUT <= next_occ == FIFO_WORDS;
    end
  end

  // read data goes back to the requester named by the tag
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      ITEM_RD_VALID_OUT <= '0;
      ITEM_RD_DATA_OUT  <= '0;
      DIR_RD_VALID_OUT  <= 1'b0;
      DIR_RD_DATA_OUT   <= '0;
      DIR_AVAIL_OUT     <= 1'b0;
    end else begin
      for (int i = 0; i < N_ITEMS; i++) begin
        ITEM_RD_VALID_OUT[i] <= RD_VALID_IN & (RD_TAG_IN == TAG_W'(i));
      end
      ITEM_RD_DATA_OUT <= RD_DATA_IN[ITEM_DATA_W-1:0];
      DIR_RD_VALID_OUT <= dir_ret;
      DIR_AVAIL_OUT    <= fifo_ret | (hold_v & !fifo_pop);
      if (dir_ret | fifo_ret) begin
        DIR_RD_DATA_OUT <= fit_width(RD_DATA_IN, NARROW_IN);
      end
    end
  end

endmodule

`default_nettype wire

// ===== bench/fe_bank_monitor.sv
// checker on the command, return and fifo ports of the bank front end
`default_nettype none

module fe_bank_monitor (
  input wire logic                            CORE_CLK_IN,
  input wire logic                            RESETN_IN,
  input wire logic                            DIRECT_SEL_IN,
  input wire logic                            NARROW_IN,
  input wire logic                            DIR_POP_IN,
  input wire logic                            DIR_AVAIL_OUT,
  input wire logic                            DIR_RD_VALID_OUT,
  input wire logic [fe_pkg::N_ITEMS-1:0]      ITEM_RD_VALID_OUT,
  input wire logic [fe_pkg::ITEM_DATA_W-1:0]  ITEM_RD_DATA_OUT,
  input wire logic [fe_pkg::ACCESS_W-1:0]     DIR_RD_DATA_OUT,
  input wire fe_pkg::fe_cmd_s                 CMD_OUT,
  input wire logic                            CMD_READY_IN,
  input wire logic                            RD_VALID_IN,
  input wire logic [fe_pkg::TAG_W-1:0]        RD_TAG_IN,
  input wire logic [fe_pkg::ACCESS_W-1:0]     RD_DATA_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  import fe_pkg::*;
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  AST_CMD_HOLD: assert property (
    CMD_OUT.valid && !CMD_READY_IN |=> $stable(CMD_OUT))
    else $error("command changed while stalled");
  AST_PAD_ZERO: assert property (
    CMD_OUT.valid && CMD_OUT.write && (NARROW_IN || !DIRECT_SEL_IN)
    |-> CMD_OUT.data[ACCESS_W-1:NARROW_W] == 64'h0)
    else $error("narrow write carries upper bits");
  AST_PART_ADDR: assert property (
    CMD_OUT.valid && !CMD_OUT.tag[1] |-> CMD_OUT.addr[23] == CMD_OUT.tag[0])
    else $error("item command outside its partition");
  AST_ONE_PATH: assert property (
    CMD_OUT.valid |-> CMD_OUT.tag[1] == DIRECT_SEL_IN)
    else $error("command from the unselected path");
  AST_ITEM_RET: assert property (
    RD_VALID_IN && !RD_TAG_IN[1] |=>
    ITEM_RD_VALID_OUT == (N_ITEMS'(1) << $past(RD_TAG_IN[0])) &&
    ITEM_RD_DATA_OUT == $past(RD_DATA_IN[ITEM_DATA_W-1:0]))
    else $error("item return late or wrong");
  AST_DIR_RET: assert property (
    RD_VALID_IN && RD_TAG_IN == TAG_DIRECT |=> DIR_RD_VALID_OUT &&
    DIR_RD_DATA_OUT == (NARROW_IN ? {64'h0, $past(RD_DATA_IN[63:0])}
                                  : $past(RD_DATA_IN)))
    else $error("direct return late or wrong");
  AST_FIFO_AVAIL: assert property (
    RD_VALID_IN && RD_TAG_IN == TAG_FIFO |=> DIR_AVAIL_OUT)
    else $error("fifo word not made available");
  AST_POP_CLEAR: assert property (
    DIR_POP_IN && DIR_AVAIL_OUT && !RD_VALID_IN |=> !DIR_AVAIL_OUT)
    else $error("available stayed up after a pop");
endmodule

bind fe_bank_front fe_bank_monitor i_mon (
  .CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN),
  .DIRECT_SEL_IN(DIRECT_SEL_IN), .NARROW_IN(NARROW_IN),
  .DIR_POP_IN(DIR_POP_IN), .DIR_AVAIL_OUT(DIR_AVAIL_OUT),
  .DIR_RD_VALID_OUT(DIR_RD_VALID_OUT), .ITEM_RD_VALID_OUT(ITEM_RD_VALID_OUT),
  .ITEM_RD_DATA_OUT(ITEM_RD_DATA_OUT), .DIR_RD_DATA_OUT(DIR_RD_DATA_OUT),
  .CMD_OUT(CMD_OUT), .CMD_READY_IN(CMD_READY_IN), .RD_VALID_IN(RD_VALID_IN),
  .RD_TAG_IN(RD_TAG_IN), .RD_DATA_IN(RD_DATA_IN));

`default_nettype wire

// ===== bench/fe_dram_model.sv
// behavioural dram bank answering the front end commands
`default_nettype none

module fe_dram_model (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     stall_in,
  input  wire fe_pkg::fe_cmd_s          cmd_in,
  output logic                          ready_out,
  output logic                          rd_valid_out,
  output logic [fe_pkg::TAG_W-1:0]      rd_tag_out,
  output logic [fe_pkg::ACCESS_W-1:0]   rd_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import fe_pkg::*;
  logic [ACCESS_W-1:0] mem [logic [BANK_ADDR_W-1:0]];

  initial begin
    rd_valid_out = 1'b0;
    rd_tag_out = '0;
    rd_data_out = '0;
  end
  assign ready_out = !stall_in;
  always @(posedge clk_in) begin
    rd_valid_out <= 1'b0;
    // idle return lines toggle so a stale word never looks valid
    rd_tag_out <= ~rd_tag_out;
    rd_data_out <= ~rd_data_out;
    if (rst_n_in && cmd_in.valid && ready_out) begin
      if (cmd_in.write) begin
        mem[cmd_in.addr] = cmd_in.data;
      end else begin
        rd_valid_out <= 1'b1;
        rd_tag_out <= cmd_in.tag;
        rd_data_out <= mem.exists(cmd_in.addr) ? mem[cmd_in.addr]
                                               : ~ACCESS_W'(cmd_in.addr);
      end
    end
  end
endmodule

`default_nettype wire

// ===== bench/tb_dram_bank_memory_item_front_end.sv
// self-checking bench for the dram bank front end
`default_nettype none

module tb_dram_bank_memory_item_front_end;
  timeunit 1ns;
  timeprecision 1ps;
  import fe_pkg::*;
  logic CORE_CLK_IN, RESETN_IN, DIRECT_SEL_IN, FIFO_MODE_IN, NARROW_IN;
  logic DIR_READY_OUT, DIR_FULL_OUT, DIR_POP_IN, DIR_AVAIL_OUT;
  logic DIR_RD_VALID_OUT, CMD_READY_IN, RD_VALID_IN, slow;
  logic [N_ITEMS-1:0]     ITEM_READY_OUT, ITEM_RD_VALID_OUT;
  logic [N_ITEMS:0]       RANGE_ERR_OUT;
  logic [ITEM_DATA_W-1:0] ITEM_RD_DATA_OUT;
  logic [ACCESS_W-1:0]    DIR_RD_DATA_OUT, RD_DATA_IN;
  logic [TAG_W-1:0]       RD_TAG_IN;
  fe_item_req_s [N_ITEMS-1:0] ITEM_REQ_IN;
  fe_req_s                DIR_REQ_IN;
  fe_cmd_s                CMD_OUT;
  logic                   stall = 1'b0;
  logic [31:0]            seed = 32'h6FC2;
  logic [ACCESS_W-1:0]    exp_q [6][$];
  logic [ACCESS_W-1:0]    wd [2][6];
  logic [ACCESS_W-1:0]    dw [4];
  int                     err_count = 0;
  int                     n_compared = 0;
  int                     w;

  fe_bank_front i_dut (
    .CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN),
    .DIRECT_SEL_IN(DIRECT_SEL_IN), .FIFO_MODE_IN(FIFO_MODE_IN),
    .NARROW_IN(NARROW_IN), .ITEM_REQ_IN(ITEM_REQ_IN),
    .ITEM_READY_OUT(ITEM_READY_OUT), .RANGE_ERR_OUT(RANGE_ERR_OUT),
    .ITEM_RD_VALID_OUT(ITEM_RD_VALID_OUT), .ITEM_RD_DATA_OUT(ITEM_RD_DATA_OUT),
    .DIR_REQ_IN(DIR_REQ_IN), .DIR_READY_OUT(DIR_READY_OUT),
    .DIR_FULL_OUT(DIR_FULL_OUT), .DIR_POP_IN(DIR_POP_IN),
    .DIR_AVAIL_OUT(DIR_AVAIL_OUT), .DIR_RD_VALID_OUT(DIR_RD_VALID_OUT),
    .DIR_RD_DATA_OUT(DIR_RD_DATA_OUT), .CMD_OUT(CMD_OUT),
    .CMD_READY_IN(CMD_READY_IN), .RD_VALID_IN(RD_VALID_IN),
    .RD_TAG_IN(RD_TAG_IN), .RD_DATA_IN(RD_DATA_IN));

  fe_dram_model i_dram (
    .clk_in(CORE_CLK_IN), .rst_n_in(RESETN_IN), .stall_in(stall),
    .cmd_in(CMD_OUT), .ready_out(CMD_READY_IN), .rd_valid_out(RD_VALID_IN),
    .rd_tag_out(RD_TAG_IN), .rd_data_out(RD_DATA_IN));

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    CORE_CLK_IN = 1'b0;
    forever #2 CORE_CLK_IN = ~CORE_CLK_IN;
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [ACCESS_W-1:0] pull(input int s);
    return exp_q[s].size() ? exp_q[s].pop_front() : 'x;
  endfunction
  task check(input string nm, input logic [ACCESS_W-1:0] seen, ex);
    n_compared++;
    if (seen !== ex) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task close_out;
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task do_reset(input logic sel, fm, nw);
    RESETN_IN <= 1'b0;
    DIRECT_SEL_IN <= sel;
    FIFO_MODE_IN <= fm;
    NARROW_IN <= nw;
    repeat (6) @(posedge CORE_CLK_IN);
    RESETN_IN <= 1'b1;
    repeat (2) @(posedge CORE_CLK_IN);
  endtask
  // requests stay valid until an edge samples ready high
  task automatic ireq(input int i, input logic wr, input logic [23:0] a,
                      input logic [63:0] d);
    int n;
    ITEM_REQ_IN[i] <= '{1'b1, wr, a, d};
    n = 0;
    do begin @(posedge CORE_CLK_IN); n++; end
    while (ITEM_READY_OUT[i] !== 1'b1 && n < 999);
    if (ITEM_READY_OUT[i] !== 1'b1) err_count++;
  endtask
  task automatic dreq(input logic wr, input logic [23:0] a,
                      input logic [ACCESS_W-1:0] d);
    int n;
    DIR_REQ_IN <= '{1'b1, wr, a, d};
    n = 0;
    do begin @(posedge CORE_CLK_IN); n++; end
    while (!(DIR_READY_OUT === 1'b1 && DIR_FULL_OUT === 1'b0) && n < 999);
    if (!(DIR_READY_OUT === 1'b1 && DIR_FULL_OUT === 1'b0)) err_count++;
  endtask
  task automatic iseq(input int i);
    for (int k = 0; k < 6; k++) begin
      wd[i][k] = {64'h0, rnd(), rnd()};
      ireq(i, 1'b1, 24'(k), wd[i][k][63:0]);
    end
    for (int k = 0; k < 6; k++) begin
      exp_q[i].push_back(wd[i][k]);
      ireq(i, 1'b0, 24'(k), 64'h0);
    end
    exp_q[4 + i].push_back(ACCESS_W'(i));
    ireq(i, 1'b1, ITEM_WORDS[23:0], 64'h0);
    ITEM_REQ_IN[i].valid <= 1'b0;
  endtask

  // ****************************************************************
  // observer and stimulus
  // ****************************************************************
  // bank stalls pace the request rate
  always @(posedge CORE_CLK_IN) stall <= slow && (rnd() % 3 == 0);
  always @(posedge CORE_CLK_IN) if (RESETN_IN) begin
    for (int b = 0; b < N_ITEMS; b++) begin
      if (ITEM_RD_VALID_OUT[b] === 1'b1)
        check("item read", {64'h0, ITEM_RD_DATA_OUT}, pull(b));
      if (RANGE_ERR_OUT[b] === 1'b1)
        check("range error", ACCESS_W'(b), pull(4 + b));
    end
    if (RANGE_ERR_OUT[N_ITEMS] !== 1'b0)
      check("direct range", ACCESS_W'(RANGE_ERR_OUT[N_ITEMS]), '0);
    if (DIR_RD_VALID_OUT === 1'b1)
      check("direct read", DIR_RD_DATA_OUT, pull(2));
    if (DIR_POP_IN && DIR_AVAIL_OUT === 1'b1)
      check("fifo word", DIR_RD_DATA_OUT, pull(3));
  end
  initial begin
    repeat (30000) @(posedge CORE_CLK_IN);
    err_count++;
    close_out();
  end
  initial begin
    ITEM_REQ_IN = '0;
    DIR_REQ_IN = '0;
    DIR_POP_IN = 1'b0;
    slow = 1'b1;
    do_reset(1'b0, 1'b0, 1'b0);
    // both items contend under a stalling bank
    fork
      iseq(0);
      iseq(1);
    join
    repeat (100) @(posedge CORE_CLK_IN);
    for (int n = 0; n < 2; n++) begin
      do_reset(1'b1, 1'b0, n[0]);
      for (int k = 0; k < 4; k++) begin
        dw[k] = {rnd(), rnd(), rnd(), rnd()};
        dreq(1'b1, 24'(256 + k), dw[k]);
      end
      for (int k = 0; k < 4; k++) begin
        exp_q[2].push_back(n ? {64'h0, dw[k][63:0]} : dw[k]);
        dreq(1'b0, 24'(256 + k), '0);
      end
      // item words seen through the whole bank
      for (int k = 0; k < 6 && n == 0; k++) begin
        exp_q[2].push_back(wd[1][k]);
        dreq(1'b0, ITEM1_BASE + 24'(k), '0);
      end
      DIR_REQ_IN.valid <= 1'b0;
      repeat (100) @(posedge CORE_CLK_IN);
    end
    // fifo on the wide and on the narrow port
    for (int n = 0; n < 2; n++) begin
      do_reset(1'b1, 1'b1, n[0]);
      for (int k = 0; k < 4; k++) begin
        dw[k] = {rnd(), rnd(), rnd(), rnd()};
        exp_q[3].push_back(n ? {64'h0, dw[k][63:0]} : dw[k]);
        dreq(1'b1, 24'h0, dw[k]);
      end
      DIR_REQ_IN.valid <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        w = 0;
        do begin @(posedge CORE_CLK_IN); w++; end
        while (DIR_AVAIL_OUT !== 1'b1 && w < 999);
        if (DIR_AVAIL_OUT !== 1'b1) err_count++;
        DIR_POP_IN <= 1'b1;
        @(posedge CORE_CLK_IN);
        DIR_POP_IN <= 1'b0;
      end
      repeat (50) @(posedge CORE_CLK_IN);
    end
    for (int s = 0; s < 6; s++)
      check("leftover", ACCESS_W'(exp_q[s].size()), '0);
    close_out();
  end
endmodule

`default_nettype wire
